// file: core/rpf_pkg.sv
// Purpose: constants shared by the rx pause/control frame filter
// Assumes: 32-bit AHB-Lite register map, 64-bit receive stream
// Notes: all offsets are byte addresses
package rpf_pkg;
  localparam int ADDR_W = 48;
  localparam int TYPE_W = 16;
  localparam int PAUSE_W = 9;
  localparam int DATA_W = 64;
  localparam int KEEP_W = 8;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PAUSE_EN = 8'h04;
  localparam logic [7:0] OFF_UCAST_LO = 8'h08;
  localparam logic [7:0] OFF_UCAST_HI = 8'h0C;
  localparam logic [7:0] OFF_MCAST_LO = 8'h10;
  localparam logic [7:0] OFF_MCAST_HI = 8'h14;
  localparam logic [7:0] OFF_SRC_LO = 8'h18;
  localparam logic [7:0] OFF_SRC_HI = 8'h1C;
  localparam logic [7:0] OFF_G_ETYPE = 8'h20;
  localparam logic [7:0] OFF_G_OPCODE = 8'h24;
  localparam logic [7:0] OFF_P_ETYPE = 8'h28;
  localparam logic [7:0] OFF_P_OPCODE = 8'h2C;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam int DECODE_W = 8;
  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int CTRL_FWD = 0;
  localparam int CTRL_CHK_ACK = 1;
  localparam int CTRL_G_EN = 2;
  localparam int CTRL_G_CHK = 3;
  localparam int CTRL_P_EN = 8;
  localparam int CTRL_P_CHK = 9;
  localparam int CHK_MCAST = 0;
  localparam int CHK_UCAST = 1;
  localparam int CHK_SRC = 2;
  localparam int CHK_ETYPE = 3;
  localparam int CHK_OPCODE = 4;
  localparam int CTRL_W = 14;
  localparam int OPMAX_LSB = 16;
  localparam int STAT_G_HIT = 16;
  localparam int STAT_P_HIT = 17;
  localparam int GLOBAL_BIT = 8;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [CTRL_W-1:0] RST_CTRL = 14'h3FFC;
  localparam logic [PAUSE_W-1:0] RST_PAUSE_EN = 9'h1FF;
  localparam logic [ADDR_W-1:0] RST_UCAST = 48'h000000000000;
  localparam logic [ADDR_W-1:0] RST_MCAST = 48'h0180C2000001;
  localparam logic [ADDR_W-1:0] RST_SRC = 48'h000000000000;
  localparam logic [TYPE_W-1:0] RST_ETYPE = 16'h8808;
  localparam logic [TYPE_W-1:0] RST_G_OPMIN = 16'h0001;
  localparam logic [TYPE_W-1:0] RST_G_OPMAX = 16'h0001;
  localparam logic [TYPE_W-1:0] RST_P_OPMIN = 16'h0101;
  localparam logic [TYPE_W-1:0] RST_P_OPMAX = 16'h0101;
  // ------------------------------------------------------------
  // header beat positions
  // ------------------------------------------------------------
  localparam logic [1:0] BEAT_HDR0 = 2'h0;
  localparam logic [1:0] BEAT_HDR1 = 2'h1;
  localparam logic [1:0] BEAT_PAYLD = 2'h2;
  localparam logic [1:0] BEAT_REST = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : rpf_pkg

// file: core/rpf_class_if.sv
// Purpose: one control-frame class setting plus its match result
// Assumes: driven by the filter top, read by a class matcher
// Notes: addresses are in wire order, first byte in the top bits
`timescale 1ns/1ps
interface rpf_class_if;
  logic enable;
  logic chkMcast;
  logic chkUcast;
  logic chkSrc;
  logic chkEtype;
  logic chkOpcode;
  logic [rpf_pkg::ADDR_W-1:0] mcastAddr;
  logic [rpf_pkg::ADDR_W-1:0] ucastAddr;
  logic [rpf_pkg::ADDR_W-1:0] srcAddr;
  logic [rpf_pkg::TYPE_W-1:0] etype;
  logic [rpf_pkg::TYPE_W-1:0] opMin;
  logic [rpf_pkg::TYPE_W-1:0] opMax;
  logic match;
  modport cfg (output enable, chkMcast, chkUcast, chkSrc, chkEtype, chkOpcode,
    mcastAddr, ucastAddr, srcAddr, etype, opMin, opMax, input match);
  modport chk (input enable, chkMcast, chkUcast, chkSrc, chkEtype, chkOpcode,
    mcastAddr, ucastAddr, srcAddr, etype, opMin, opMax, output match);
endinterface : rpf_class_if

// file: core/rpf_class_match.sv
// Purpose: qualifies one header against one control-frame class
// Assumes: header fields stable while match is read
// Notes: purely combinational
`timescale 1ns/1ps
module rpf_class_match #(
  parameter int ADDR_W = rpf_pkg::ADDR_W,
  parameter int TYPE_W = rpf_pkg::TYPE_W
) (
  rpf_class_if.chk cls,
  input wire logic [ADDR_W-1:0] frmDst,
  input wire logic [ADDR_W-1:0] frmSrc,
  input wire logic [TYPE_W-1:0] frmEtype,
  input wire logic [TYPE_W-1:0] frmOpcode
);
  // widths other than the carrier interface's cannot be served
  if (ADDR_W != rpf_pkg::ADDR_W || TYPE_W != rpf_pkg::TYPE_W) begin : g_bad_width
    $error("rpf_class_match: widths must match the carrier interface");
  end

  logic dstOk;
  logic srcOk;
  logic typeOk;
  logic opOk;

  // destination passes if any enabled address check hits; none enabled passes
  always_comb begin
    if (!cls.chkMcast && !cls.chkUcast) begin
      dstOk = 1'b1;
    end else begin
      dstOk = (cls.chkMcast && frmDst == cls.mcastAddr)
        || (cls.chkUcast && frmDst == cls.ucastAddr);
    end
    srcOk = !cls.chkSrc || frmSrc == cls.srcAddr;
    typeOk = !cls.chkEtype || frmEtype == cls.etype;
    opOk = !cls.chkOpcode
      || (frmOpcode >= cls.opMin && frmOpcode <= cls.opMax);
    cls.match = cls.enable && dstOk && srcOk && typeOk && opOk;
  end
endmodule : rpf_class_match

// file: core/rpf_filter.sv
// Purpose: receive pause/control frame filter with AHB-Lite settings
// Assumes: rxInValid stays high from the first to the last beat of a frame
// Notes: fixed two-cycle stream latency; byte 0 of a beat is in bits 7:0
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module rpf_filter #(
  parameter int DATA_W = rpf_pkg::DATA_W,
  parameter int PAUSE_W = rpf_pkg::PAUSE_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [DATA_W-1:0] rxInData,
  input wire logic [rpf_pkg::KEEP_W-1:0] rxInKeep,
  input wire logic rxInValid,
  input wire logic rxInLast,
  output logic [DATA_W-1:0] userData,
  output logic [rpf_pkg::KEEP_W-1:0] userKeep,
  output logic userValid,
  output logic userLast,
  input wire logic [PAUSE_W-1:0] pauseAck,
  output logic [PAUSE_W-1:0] pauseValid
);
  // header byte positions are fixed for 64-bit beats and nine pause bits
  if (DATA_W != 64 || PAUSE_W != 9) begin : g_bad_width
    $error("rpf_filter: header layout needs 64-bit beats and 9 pause bits");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [rpf_pkg::CTRL_W-1:0] ctrl;
    logic [PAUSE_W-1:0] pauseEn;
    logic [rpf_pkg::ADDR_W-1:0] ucast;
    logic [rpf_pkg::ADDR_W-1:0] mcast;
    logic [rpf_pkg::ADDR_W-1:0] srcCfg;
    logic [rpf_pkg::TYPE_W-1:0] gEtype;
    logic [rpf_pkg::TYPE_W-1:0] gOpMin;
    logic [rpf_pkg::TYPE_W-1:0] gOpMax;
    logic [rpf_pkg::TYPE_W-1:0] pEtype;
    logic [rpf_pkg::TYPE_W-1:0] pOpMin;
    logic [rpf_pkg::TYPE_W-1:0] pOpMax;
    logic [1:0] beat;
    logic [rpf_pkg::ADDR_W-1:0] hdrDst;
    logic [15:0] hdrSrcHi;
    logic gHit;
    logic pHit;
    logic frameDrop;
    logic s1Valid;
    logic s1First;
    logic s1Last;
    logic [DATA_W-1:0] s1Data;
    logic [rpf_pkg::KEEP_W-1:0] s1Keep;
    logic s2Valid;
    logic s2Drop;
    logic s2Last;
    logic [DATA_W-1:0] s2Data;
    logic [rpf_pkg::KEEP_W-1:0] s2Keep;
    logic [PAUSE_W-1:0] pending;
  } rpf_state_s;

  rpf_state_s state_reg;
  rpf_state_s state_next;

  rpf_class_if globalCls ();
  rpf_class_if priorityCls ();

  logic [rpf_pkg::ADDR_W-1:0] frmSrc;
  logic [rpf_pkg::TYPE_W-1:0] frmEtype;
  logic [rpf_pkg::TYPE_W-1:0] frmOpcode;
  logic [7:0] rdAddr;
  logic rdAccess;
  logic hdrBeat;
  logic [PAUSE_W-1:0] pauseEvent;
  logic [PAUSE_W-1:0] ackClear;

  // ------------------------------------------------------------
  // class settings and matchers
  // ------------------------------------------------------------
  always_comb begin
    globalCls.enable = state_reg.ctrl[rpf_pkg::CTRL_G_EN];
    globalCls.chkMcast = state_reg.ctrl[rpf_pkg::CTRL_G_CHK + rpf_pkg::CHK_MCAST];
    globalCls.chkUcast = state_reg.ctrl[rpf_pkg::CTRL_G_CHK + rpf_pkg::CHK_UCAST];
    globalCls.chkSrc = state_reg.ctrl[rpf_pkg::CTRL_G_CHK + rpf_pkg::CHK_SRC];
    globalCls.chkEtype = state_reg.ctrl[rpf_pkg::CTRL_G_CHK + rpf_pkg::CHK_ETYPE];
    globalCls.chkOpcode = state_reg.ctrl[rpf_pkg::CTRL_G_CHK + rpf_pkg::CHK_OPCODE];
    globalCls.mcastAddr = state_reg.mcast;
    globalCls.ucastAddr = state_reg.ucast;
    globalCls.srcAddr = state_reg.srcCfg;
    globalCls.etype = state_reg.gEtype;
    globalCls.opMin = state_reg.gOpMin;
    globalCls.opMax = state_reg.gOpMax;
    priorityCls.enable = state_reg.ctrl[rpf_pkg::CTRL_P_EN];
    priorityCls.chkMcast = state_reg.ctrl[rpf_pkg::CTRL_P_CHK + rpf_pkg::CHK_MCAST];
    priorityCls.chkUcast = state_reg.ctrl[rpf_pkg::CTRL_P_CHK + rpf_pkg::CHK_UCAST];
    priorityCls.chkSrc = state_reg.ctrl[rpf_pkg::CTRL_P_CHK + rpf_pkg::CHK_SRC];
    priorityCls.chkEtype = state_reg.ctrl[rpf_pkg::CTRL_P_CHK + rpf_pkg::CHK_ETYPE];
    priorityCls.chkOpcode = state_reg.ctrl[rpf_pkg::CTRL_P_CHK + rpf_pkg::CHK_OPCODE];
    priorityCls.mcastAddr = state_reg.mcast;
    priorityCls.ucastAddr = state_reg.ucast;
    priorityCls.srcAddr = state_reg.srcCfg;
    priorityCls.etype = state_reg.pEtype;
    priorityCls.opMin = state_reg.pOpMin;
    priorityCls.opMax = state_reg.pOpMax;
  end

  // second header beat: source bytes 8..11, type bytes 12..13, opcode 14..15
  assign frmSrc = {state_reg.hdrSrcHi, rxInData[7:0], rxInData[15:8],
    rxInData[23:16], rxInData[31:24]};
  assign frmEtype = {rxInData[39:32], rxInData[47:40]};
  assign frmOpcode = {rxInData[55:48], rxInData[63:56]};

  rpf_class_match #(.ADDR_W(rpf_pkg::ADDR_W), .TYPE_W(rpf_pkg::TYPE_W)) globalMatch (
    .cls(globalCls.chk),
    .frmDst(state_reg.hdrDst),
    .frmSrc(frmSrc),
    .frmEtype(frmEtype),
    .frmOpcode(frmOpcode)
  );

  rpf_class_match #(.ADDR_W(rpf_pkg::ADDR_W), .TYPE_W(rpf_pkg::TYPE_W)) priorityMatch (
    .cls(priorityCls.chk),
    .frmDst(state_reg.hdrDst),
    .frmSrc(frmSrc),
    .frmEtype(frmEtype),
    .frmOpcode(frmOpcode)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  assign rdAddr = haddr[rpf_pkg::DECODE_W-1:0];
  assign rdAccess = hsel && htrans == rpf_pkg::HTRANS_NONSEQ && hready;
  assign hdrBeat = rxInValid && state_reg.beat == rpf_pkg::BEAT_HDR1;

  always_comb begin
    state_next = state_reg;
    // ---- register bus ----
    state_next.wrPend = rdAccess && hwrite;
    state_next.wrAddr = rdAddr;
    state_next.rdata = 32'h00000000;
    if (rdAccess && !hwrite && haddr[31:rpf_pkg::DECODE_W] == '0) begin
      case (rdAddr)
        rpf_pkg::OFF_CTRL: state_next.rdata = {18'h00000, state_reg.ctrl};
        rpf_pkg::OFF_PAUSE_EN: state_next.rdata = {23'h000000, state_reg.pauseEn};
        rpf_pkg::OFF_UCAST_LO: state_next.rdata = state_reg.ucast[31:0];
        rpf_pkg::OFF_UCAST_HI: state_next.rdata = {16'h0000, state_reg.ucast[47:32]};
        rpf_pkg::OFF_MCAST_LO: state_next.rdata = state_reg.mcast[31:0];
        rpf_pkg::OFF_MCAST_HI: state_next.rdata = {16'h0000, state_reg.mcast[47:32]};
        rpf_pkg::OFF_SRC_LO: state_next.rdata = state_reg.srcCfg[31:0];
        rpf_pkg::OFF_SRC_HI: state_next.rdata = {16'h0000, state_reg.srcCfg[47:32]};
        rpf_pkg::OFF_G_ETYPE: state_next.rdata = {16'h0000, state_reg.gEtype};
        rpf_pkg::OFF_G_OPCODE: state_next.rdata = {state_reg.gOpMax, state_reg.gOpMin};
        rpf_pkg::OFF_P_ETYPE: state_next.rdata = {16'h0000, state_reg.pEtype};
        rpf_pkg::OFF_P_OPCODE: state_next.rdata = {state_reg.pOpMax, state_reg.pOpMin};
        rpf_pkg::OFF_STATUS: state_next.rdata = {14'h0000, state_reg.pHit, state_reg.gHit,
          7'h00, state_reg.pending};
        default: state_next.rdata = 32'h00000000;
      endcase
    end
    if (state_reg.wrPend) begin
      case (state_reg.wrAddr)
        rpf_pkg::OFF_CTRL: state_next.ctrl = hwdata[rpf_pkg::CTRL_W-1:0];
        rpf_pkg::OFF_PAUSE_EN: state_next.pauseEn = hwdata[PAUSE_W-1:0];
        rpf_pkg::OFF_UCAST_LO: state_next.ucast[31:0] = hwdata;
        rpf_pkg::OFF_UCAST_HI: state_next.ucast[47:32] = hwdata[15:0];
        rpf_pkg::OFF_MCAST_LO: state_next.mcast[31:0] = hwdata;
        rpf_pkg::OFF_MCAST_HI: state_next.mcast[47:32] = hwdata[15:0];
        rpf_pkg::OFF_SRC_LO: state_next.srcCfg[31:0] = hwdata;
        rpf_pkg::OFF_SRC_HI: state_next.srcCfg[47:32] = hwdata[15:0];
        rpf_pkg::OFF_G_ETYPE: state_next.gEtype = hwdata[15:0];
        rpf_pkg::OFF_G_OPCODE: begin
          state_next.gOpMin = hwdata[15:0];
          state_next.gOpMax = hwdata[31:rpf_pkg::OPMAX_LSB];
        end
        rpf_pkg::OFF_P_ETYPE: state_next.pEtype = hwdata[15:0];
        rpf_pkg::OFF_P_OPCODE: begin
          state_next.pOpMin = hwdata[15:0];
          state_next.pOpMax = hwdata[31:rpf_pkg::OPMAX_LSB];
        end
        default: state_next.ctrl = state_reg.ctrl;
      endcase
    end
    // ---- header capture and classification ----
    if (rxInValid) begin
      if (rxInLast) begin
        state_next.beat = rpf_pkg::BEAT_HDR0;
      end else if (state_reg.beat != rpf_pkg::BEAT_REST) begin
        state_next.beat = state_reg.beat + 2'h1;
      end
      if (state_reg.beat == rpf_pkg::BEAT_HDR0) begin
        for (int i = 0; i < 6; i++) begin
          state_next.hdrDst[47 - 8 * i -: 8] = rxInData[8 * i +: 8];
        end
        state_next.hdrSrcHi = {rxInData[55:48], rxInData[63:56]};
        state_next.gHit = 1'b0;
        state_next.pHit = 1'b0;
      end
    end
    if (hdrBeat) begin
      state_next.gHit = globalCls.match;
      state_next.pHit = priorityCls.match;
    end
    // ---- two-stage delay so the drop decision precedes the first beat ----
    state_next.s1Valid = rxInValid;
    state_next.s1First = rxInValid && state_reg.beat == rpf_pkg::BEAT_HDR0;
    state_next.s1Last = rxInLast;
    state_next.s1Data = rxInData;
    state_next.s1Keep = rxInKeep;
    state_next.s2Valid = state_reg.s1Valid;
    state_next.s2Last = state_reg.s1Last;
    state_next.s2Data = state_reg.s1Data;
    state_next.s2Keep = state_reg.s1Keep;
    if (state_reg.s1First) begin
      // a one-beat frame is too short to be a control frame
      state_next.s2Drop = hdrBeat && !state_reg.ctrl[rpf_pkg::CTRL_FWD]
        && (globalCls.match || priorityCls.match);
      state_next.frameDrop = state_next.s2Drop;
    end else begin
      state_next.s2Drop = state_reg.frameDrop;
    end
    // ---- pause indications ----
    state_next.pending = (state_reg.ctrl[rpf_pkg::CTRL_CHK_ACK]
      ? (state_reg.pending & ~ackClear) : '0) | pauseEvent;
  end

  // pause event on the first payload beat, which carries the priority vector
  always_comb begin
    pauseEvent = '0;
    if (rxInValid && state_reg.beat == rpf_pkg::BEAT_PAYLD) begin
      pauseEvent[rpf_pkg::GLOBAL_BIT] = state_reg.gHit;
      pauseEvent[PAUSE_W-2:0] = state_reg.pHit ? rxInData[15:8] : 8'h00;
    end
  end

  // acknowledge bits count only while wait-for-ack is set
  assign ackClear = state_reg.ctrl[rpf_pkg::CTRL_CHK_ACK] ? pauseAck : '0;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.ctrl <= rpf_pkg::RST_CTRL;
      state_reg.pauseEn <= rpf_pkg::RST_PAUSE_EN;
      state_reg.ucast <= rpf_pkg::RST_UCAST;
      state_reg.mcast <= rpf_pkg::RST_MCAST;
      state_reg.srcCfg <= rpf_pkg::RST_SRC;
      state_reg.gEtype <= rpf_pkg::RST_ETYPE;
      state_reg.gOpMin <= rpf_pkg::RST_G_OPMIN;
      state_reg.gOpMax <= rpf_pkg::RST_G_OPMAX;
      state_reg.pEtype <= rpf_pkg::RST_ETYPE;
      state_reg.pOpMin <= rpf_pkg::RST_P_OPMIN;
      state_reg.pOpMax <= rpf_pkg::RST_P_OPMAX;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hrdata = state_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign userData = state_reg.s2Data;
  assign userKeep = state_reg.s2Keep;
  assign userLast = state_reg.s2Last;
  assign userValid = state_reg.s2Valid && !state_reg.s2Drop;
  assign pauseValid = state_reg.pending & state_reg.pauseEn;
endmodule : rpf_filter

// file: testbench/rpf_monitor.sv
// Purpose: port checks on the rx pause/control frame filter
// Assumes: bound to rpf_filter; settings unseen, so checks hold in every mode
// Notes: zero wait state bus, two-cycle stream latency
`timescale 1ns/1ps
module rpf_monitor #(
  parameter int DATA_W = rpf_pkg::DATA_W,
  parameter int PAUSE_W = rpf_pkg::PAUSE_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [DATA_W-1:0] rxInData,
  input wire logic [rpf_pkg::KEEP_W-1:0] rxInKeep,
  input wire logic rxInValid,
  input wire logic rxInLast,
  input wire logic [DATA_W-1:0] userData,
  input wire logic [rpf_pkg::KEEP_W-1:0] userKeep,
  input wire logic userValid,
  input wire logic userLast,
  input wire logic [PAUSE_W-1:0] pauseAck,
  input wire logic [PAUSE_W-1:0] pauseValid
);
  logic rdTaken;
  logic wrTaken;
  logic [PAUSE_W-1:0] ackHit;
  assign rdTaken = hsel && htrans == rpf_pkg::HTRANS_NONSEQ && hready && !hwrite;
  assign wrTaken = hsel && htrans == rpf_pkg::HTRANS_NONSEQ && hready && hwrite;
  assign ackHit = pauseValid & pauseAck;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_two_beats;
    rxInValid && !rxInLast ##1 rxInValid;
  endsequence
  sequence s_lone_beat;
    rxInValid && rxInLast && (!$past(rxInValid) || $past(rxInLast));
  endsequence
  a_beat_delay: assert property (
    $past(rxInValid, 2) |-> userData == $past(rxInData, 2)
    && userKeep == $past(rxInKeep, 2) && userLast == $past(rxInLast, 2))
    else $error("user beat differs from input beat");
  a_valid_cause: assert property (userValid |-> $past(rxInValid, 2))
    else $error("user beat without input beat");
  a_whole_frame: assert property (s_two_beats |-> ##2 userValid == $past(userValid))
    else $error("frame split between pass and drop");
  a_lone_pass: assert property (s_lone_beat |-> ##2 userValid)
    else $error("one-beat frame dropped");
  a_pause_cause: assert property (
    (pauseValid & ~$past(pauseValid)) != '0 |-> $past(rxInValid) || $past(wrTaken, 2))
    else $error("pause valid without a frame");
  a_ack_clear: assert property (
    ackHit != '0 && !rxInValid |=> (pauseValid & $past(ackHit)) == '0)
    else $error("acknowledged pause bit still shown");
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> !userValid && pauseValid == '0 && hrdata == 32'h0)
    else $error("outputs active after reset");
  a_rdata_idle: assert property (!$past(rdTaken) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule : rpf_monitor
bind rpf_filter rpf_monitor #(.DATA_W(DATA_W), .PAUSE_W(PAUSE_W)) mon_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .rxInData(rxInData), .rxInKeep(rxInKeep), .rxInValid(rxInValid), .rxInLast(rxInLast),
  .userData(userData), .userKeep(userKeep), .userValid(userValid), .userLast(userLast),
  .pauseAck(pauseAck), .pauseValid(pauseValid));

// file: testbench/rpf_user_model.sv
// Purpose: user logic that acknowledges pause indications
// Assumes: same clock as the filter
// Notes: acks all shown bits once they have stood ackDelay cycles
`timescale 1ns/1ps
module rpf_user_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ackOn,
  input wire logic [3:0] ackDelay,
  input wire logic [rpf_pkg::PAUSE_W-1:0] pauseValid,
  output logic [rpf_pkg::PAUSE_W-1:0] pauseAck
);
  logic [3:0] waitReg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !ackOn || pauseValid == '0) begin
      waitReg <= 4'h0;
    end else if (waitReg != 4'hF) begin
      waitReg <= waitReg + 4'h1;
    end
  end
  // bit i acknowledges pause bit i
  assign pauseAck = (ackOn && waitReg == ackDelay) ? pauseValid : '0;
endmodule : rpf_user_model

// file: testbench/rx_pause_control_frame_filter_tb_top.sv
// Purpose: self-checking bench for the rx pause/control frame filter
// Assumes: zero wait state slave
// Notes: rows are ordinary frames, awkward cases follow by hand
`timescale 1ns/1ps
module rx_pause_control_frame_filter_tb_top;
  // bad: bit1 source 1, bit0 ethertype 8809
  typedef struct packed {
    logic [13:0] ctrl;
    logic [47:0] dst;
    logic [1:0] bad;
    logic [15:0] op;
    logic [7:0] vec;
    logic [1:0] nOut;
    logic [8:0] pv;
  } rpf_row_s;
  localparam logic [47:0] MC = 48'h0180C2000001;
  localparam logic [47:0] OT = 48'h020000000099;
  localparam rpf_row_s GP = '{14'h3FFC, MC, 2'h0, 16'h0001, 8'h00, 2'h0, 9'h100};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, userValid, userLast;
  logic [63:0] rxInData = 64'h0;
  logic [63:0] userData;
  logic [7:0] rxInKeep = 8'h0;
  logic [7:0] userKeep;
  logic rxInValid = 1'b0;
  logic rxInLast = 1'b0;
  logic [8:0] pauseAck, pauseValid, pvSeen;
  logic ackOn = 1'b0;
  logic [3:0] ackDelay = 4'h3;
  logic [15:0] opTab [4] = '{16'h00FF, 16'h0100, 16'h0107, 16'h0108};
  logic inR;
  rpf_row_s rr;
  int nErrors = 0;
  int samplesChecked = 0;
  int nUser, pvCycles;
  logic [63:0] rstTab [7] = '{64'h0000000000003FFC, 64'h00000004000001FF,
    64'h00000010C2000001, 64'h0000001400000180, 64'h0000002000008808,
    64'h0000002401010101 ^ 64'h0000000001000100, 64'h0000004000000000};
  rpf_row_s rows [15] = '{
    '{14'h3FFC, MC, 2'h0, 16'h0001, 8'h00, 2'h0, 9'h100},
    '{14'h3FFD, MC, 2'h0, 16'h0001, 8'h00, 2'h3, 9'h100},
    '{14'h3FFC, MC, 2'h0, 16'h0101, 8'h5A, 2'h0, 9'h05A},
    '{14'h3FFC, OT, 2'h0, 16'h0001, 8'h00, 2'h3, 9'h000},
    '{14'h3FE4, OT, 2'h0, 16'h0001, 8'h00, 2'h0, 9'h100},
    '{14'h3FF8, MC, 2'h0, 16'h0001, 8'h00, 2'h3, 9'h000},
    '{14'h3EFC, MC, 2'h0, 16'h0101, 8'h5A, 2'h3, 9'h000},
    '{14'h3FFC, MC, 2'h2, 16'h0001, 8'h00, 2'h3, 9'h000},
    '{14'h3FDC, MC, 2'h2, 16'h0001, 8'h00, 2'h0, 9'h100},
    '{14'h3FFC, MC, 2'h1, 16'h0001, 8'h00, 2'h3, 9'h000},
    '{14'h3FFC, MC, 2'h0, 16'h0002, 8'h00, 2'h3, 9'h000},
    '{14'h3F7C, MC, 2'h0, 16'h0002, 8'h00, 2'h0, 9'h100},
    '{14'h2FFC, MC, 2'h1, 16'h0101, 8'h81, 2'h0, 9'h081},
    '{14'h1FFC, MC, 2'h0, 16'h0102, 8'h81, 2'h0, 9'h081},
    '{14'h39FC, OT, 2'h0, 16'h0101, 8'h81, 2'h0, 9'h081}};
  rpf_filter dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxInData(rxInData),
    .rxInKeep(rxInKeep), .rxInValid(rxInValid), .rxInLast(rxInLast), .userData(userData),
    .userKeep(userKeep), .userValid(userValid), .userLast(userLast),
    .pauseAck(pauseAck), .pauseValid(pauseValid));
  rpf_user_model model_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .ackOn(ackOn),
    .ackDelay(ackDelay), .pauseValid(pauseValid), .pauseAck(pauseAck));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (userValid === 1'b1) begin
      nUser = nUser + 1;
    end
    pvSeen = pvSeen | pauseValid;
    if (pauseValid[8] === 1'b1) begin
      pvCycles = pvCycles + 1;
    end
  end
  task automatic give_verdict();
    $display("compared %0d values, %0d mismatches", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_ready();
    int k;
    k = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 15) begin
        nErrors++;
        give_verdict();
      end
      @(posedge ref_clk);
    end
  endtask : wait_ready
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= addr;
    hwrite <= wr;
    htrans <= rpf_pkg::HTRANS_NONSEQ;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer
  task automatic send(input logic [127:0] hb, input logic [7:0] vec, input int nb);
    logic [191:0] fr;
    fr[191:128] = {48'h0, vec, 8'h00};
    for (int i = 0; i < 16; i++) fr[8*i +: 8] = hb[127-8*i -: 8];
    @(negedge ref_clk);
    nUser = 0;
    pvSeen = 9'h0;
    pvCycles = 0;
    @(posedge ref_clk);
    for (int b = 0; b < nb; b++) begin
      rxInData <= fr[64*b +: 64];
      rxInKeep <= 8'hFF;
      rxInValid <= 1'b1;
      rxInLast <= (b == nb - 1);
      @(posedge ref_clk);
    end
    rxInValid <= 1'b0;
    rxInLast <= 1'b0;
    rxInData <= ~fr[64*(nb-1) +: 64];
    repeat (8) @(posedge ref_clk);
  endtask : send
  task automatic run_case(input rpf_row_s r, input int id);
    xfer(1'b1, 32'h0, {18'h0, r.ctrl});
    send({r.dst, 47'h0, r.bad[1], 16'h8808 | {15'h0, r.bad[0]}, r.op}, r.vec, 3);
    check(nUser, {30'h0, r.nOut});
    check({23'h0, pvSeen}, {23'h0, r.pv});
    $display("case %0d done", id);
  endtask : run_case
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, rstTab[i][63:32], 32'h0);
      check(rd, rstTab[i][31:0]);
    end
    $display("reset value reads done");
    for (int i = 0; i < 15; i++) run_case(rows[i], i);
    xfer(1'b1, 32'h08, 32'h33445566);
    xfer(1'b1, 32'h0C, 32'h00001122);
    rr = GP;
    rr.dst = 48'h112233445566;
    run_case(rr, 20);
    xfer(1'b1, 32'h2C, 32'h01070100);
    for (int i = 0; i < 4; i++) begin
      inR = opTab[i] >= 16'h0100 && opTab[i] <= 16'h0107;
      rr = '{14'h3FFC, MC, 2'h0, opTab[i], 8'h81, inR ? 2'h0 : 2'h3, inR ? 9'h081 : 9'h0};
      run_case(rr, 30 + i);
    end
    xfer(1'b1, 32'h04, 32'h000000FF);
    rr = GP;
    rr.pv = 9'h0;
    run_case(rr, 40);
    xfer(1'b0, 32'h30, 32'h0);
    check({31'h0, rd[16]}, 32'h1);
    xfer(1'b1, 32'h04, 32'h000001FF);
    ackOn <= 1'b1;
    rr = GP;
    rr.ctrl = 14'h3FFE;
    run_case(rr, 50);
    check(pvCycles, {28'h0, ackDelay} + 32'h1);
    ackOn <= 1'b0;
    run_case(GP, 51);
    check(pvCycles, 32'h1);
    send({MC, 48'h0, 16'h8808, 16'h0001}, 8'h00, 1);
    check(nUser, 32'h1);
    $display("one-beat case done");
    rr = '{14'h3FFC, 48'h112233445566, 2'h0, 16'h0101, 8'h81, 2'h0, 9'h081};
    run_case(rr, 60);
    xfer(1'b1, 32'h18, 32'h00000001);
    rr = GP;
    rr.bad = 2'h2;
    run_case(rr, 61);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    xfer(1'b0, 32'h0, 32'h0);
    check(rd, 32'h00003FFC);
    xfer(1'b0, 32'h18, 32'h0);
    check(rd, 32'h00000000);
    xfer(1'b0, 32'h2C, 32'h0);
    check(rd, 32'h01010101);
    $display("reset case done");
    give_verdict();
  end
endmodule : rx_pause_control_frame_filter_tb_top
